// File: design/prio_regs_defs.svh
// register offsets, field positions and reset values for the priority bank
// assumes a 32-bit axi4-lite word per register, byte addressed
`ifndef PRIO_REGS_DEFS_SVH
`define PRIO_REGS_DEFS_SVH

`define PRIO_ADDR_W 6
`define PRIO_OFF_11 6'h00
`define PRIO_OFF_12 6'h04
`define PRIO_OFF_13 6'h08
`define PRIO_OFF_15 6'h0c
`define PRIO_OFF_16 6'h10
`define PRIO_OFF_18 6'h14
`define PRIO_OFF_19 6'h18
`define PRIO_OFF_20 6'h1c

`define PRIO_FIELD_RST 3'h4
`define PRIO_DISABLED 3'h0

`define PRIO_MASK_11 16'h0077
`define PRIO_MASK_12 16'h0770
`define PRIO_MASK_13 16'h0770
`define PRIO_MASK_15 16'h0700
`define PRIO_MASK_16 16'h7770
`define PRIO_MASK_18 16'h0007
`define PRIO_MASK_19 16'h0070
`define PRIO_MASK_20 16'h7770

`define PRIO_RST_11 16'h0044
`define PRIO_RST_12 16'h0440
`define PRIO_RST_13 16'h0440
`define PRIO_RST_15 16'h0400
`define PRIO_RST_16 16'h4440
`define PRIO_RST_18 16'h0004
`define PRIO_RST_19 16'h0040
`define PRIO_RST_20 16'h4440

`define AXI_RESP_OKAY 2'h0
`define AXI_RESP_SLVERR 2'h2

`endif

// File: design/prio_regs_pkg.sv
// types for the interrupt priority register bank
// assumes the defs header carries all numeric constants
package prio_regs_pkg;
	typedef logic [15:0] prio_word_t;
	typedef logic [2:0] prio_field_t;

	typedef enum logic [1:0] {
		wr_idle = 2'h0,
		wr_resp = 2'h1
	} wr_state_e;

	typedef enum logic [1:0] {
		rd_idle = 2'h0,
		rd_resp = 2'h1
	} rd_state_e;

	typedef struct packed {
		prio_word_t pc11;
		prio_word_t pc12;
		prio_word_t pc13;
		prio_word_t pc15;
		prio_word_t pc16;
		prio_word_t pc18;
		prio_word_t pc19;
		prio_word_t pc20;
		wr_state_e wst;
		logic aw_held;
		logic [5:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic [1:0] bresp;
		rd_state_e rst;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;
endpackage

// File: design/interrupt_priority_regs_b.sv
// bank of eight 16-bit interrupt priority registers on an axi4-lite slave
// assumes one clock aclk, synchronous active-low reset, arbiter reads the *_prio outputs
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "prio_regs_defs.svh"

module interrupt_priority_regs_b (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [`PRIO_ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // write protection, unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [`PRIO_ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // read protection, unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	output logic [2:0] parallel_port_prio, // priority, 0 disables
	output logic [2:0] out_compare8_prio, // priority, 0 disables
	output logic [2:0] i2c2_master_prio, // priority, 0 disables
	output logic [2:0] i2c2_slave_prio, // priority, 0 disables
	output logic [2:0] ext_irq4_prio, // priority, 0 disables
	output logic [2:0] ext_irq3_prio, // priority, 0 disables
	output logic [2:0] calendar_clock_prio, // priority, 0 disables
	output logic [2:0] checksum_error_prio, // priority, 0 disables
	output logic [2:0] serial2_error_prio, // priority, 0 disables
	output logic [2:0] serial1_error_prio, // priority, 0 disables
	output logic [2:0] low_voltage_prio, // priority, 0 disables
	output logic [2:0] charge_timer_prio, // priority, 0 disables
	output logic [2:0] serial3_tx_prio, // priority, 0 disables
	output logic [2:0] serial3_rx_prio, // priority, 0 disables
	output logic [2:0] serial3_error_prio // priority, 0 disables
);

	prio_regs_pkg::state_s state_reg;
	prio_regs_pkg::state_s state_next;

	// merge a write into a register, only implemented bits move
	function automatic prio_regs_pkg::prio_word_t merge(
		input prio_regs_pkg::prio_word_t old,
		input logic [31:0] data,
		input logic [3:0] strb,
		input prio_regs_pkg::prio_word_t mask
	);
		prio_regs_pkg::prio_word_t lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~(lanes & mask)) | (data[15:0] & lanes & mask);
	endfunction

	function automatic logic known(input logic [`PRIO_ADDR_W-1:0] a);
		case (a)
			`PRIO_OFF_11, `PRIO_OFF_12, `PRIO_OFF_13, `PRIO_OFF_15,
			`PRIO_OFF_16, `PRIO_OFF_18, `PRIO_OFF_19, `PRIO_OFF_20: known = 1'b1;
			default: known = 1'b0;
		endcase
	endfunction

	logic aw_take;
	logic w_take;
	logic ar_take;
	logic [`PRIO_ADDR_W-1:0] wa;
	logic [`PRIO_ADDR_W-1:0] ra;
	logic [31:0] wd;
	logic [3:0] ws;
	prio_regs_pkg::prio_word_t rword;

	always_comb begin
		state_next = state_reg;
		aw_take = (state_reg.wst == prio_regs_pkg::wr_idle) && !state_reg.aw_held
			&& s_axi_awvalid;
		w_take = (state_reg.wst == prio_regs_pkg::wr_idle) && !state_reg.w_held
			&& s_axi_wvalid;
		ar_take = (state_reg.rst == prio_regs_pkg::rd_idle) && s_axi_arvalid;
		wa = state_reg.aw_held ? state_reg.aw_addr : s_axi_awaddr;
		wd = state_reg.w_held ? state_reg.w_data : s_axi_wdata;
		ws = state_reg.w_held ? state_reg.w_strb : s_axi_wstrb;
		ra = s_axi_araddr;
		rword = 16'h0000;
		case (state_reg.wst)
			prio_regs_pkg::wr_idle: begin
				if (aw_take) begin
					state_next.aw_held = 1'b1;
					state_next.aw_addr = s_axi_awaddr;
				end
				if (w_take) begin
					state_next.w_held = 1'b1;
					state_next.w_data = s_axi_wdata;
					state_next.w_strb = s_axi_wstrb;
				end
				if ((state_reg.aw_held || aw_take) && (state_reg.w_held || w_take)) begin
					state_next.aw_held = 1'b0;
					state_next.w_held = 1'b0;
					state_next.wst = prio_regs_pkg::wr_resp;
					state_next.bresp = known(wa) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
					case (wa)
						`PRIO_OFF_11: state_next.pc11 = merge(state_reg.pc11, wd, ws, `PRIO_MASK_11);
						`PRIO_OFF_12: state_next.pc12 = merge(state_reg.pc12, wd, ws, `PRIO_MASK_12);
						`PRIO_OFF_13: state_next.pc13 = merge(state_reg.pc13, wd, ws, `PRIO_MASK_13);
						`PRIO_OFF_15: state_next.pc15 = merge(state_reg.pc15, wd, ws, `PRIO_MASK_15);
						`PRIO_OFF_16: state_next.pc16 = merge(state_reg.pc16, wd, ws, `PRIO_MASK_16);
						`PRIO_OFF_18: state_next.pc18 = merge(state_reg.pc18, wd, ws, `PRIO_MASK_18);
						`PRIO_OFF_19: state_next.pc19 = merge(state_reg.pc19, wd, ws, `PRIO_MASK_19);
						`PRIO_OFF_20: state_next.pc20 = merge(state_reg.pc20, wd, ws, `PRIO_MASK_20);
						default: begin
						end
					endcase
				end
			end
			prio_regs_pkg::wr_resp: begin
				if (s_axi_bready) begin
					state_next.wst = prio_regs_pkg::wr_idle;
				end
			end
			default: state_next.wst = prio_regs_pkg::wr_idle;
		endcase
		case (ra)
			`PRIO_OFF_11: rword = state_reg.pc11;
			`PRIO_OFF_12: rword = state_reg.pc12;
			`PRIO_OFF_13: rword = state_reg.pc13;
			`PRIO_OFF_15: rword = state_reg.pc15;
			`PRIO_OFF_16: rword = state_reg.pc16;
			`PRIO_OFF_18: rword = state_reg.pc18;
			`PRIO_OFF_19: rword = state_reg.pc19;
			`PRIO_OFF_20: rword = state_reg.pc20;
			default: rword = 16'h0000;
		endcase
		case (state_reg.rst)
			prio_regs_pkg::rd_idle: begin
				if (ar_take) begin
					state_next.rst = prio_regs_pkg::rd_resp;
					state_next.rdata = {16'h0000, rword};
					state_next.rresp = known(ra) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				end
			end
			prio_regs_pkg::rd_resp: begin
				if (s_axi_rready) begin
					state_next.rst = prio_regs_pkg::rd_idle;
				end
			end
			default: state_next.rst = prio_regs_pkg::rd_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= '0;
			state_reg.pc11 <= `PRIO_RST_11;
			state_reg.pc12 <= `PRIO_RST_12;
			state_reg.pc13 <= `PRIO_RST_13;
			state_reg.pc15 <= `PRIO_RST_15;
			state_reg.pc16 <= `PRIO_RST_16;
			state_reg.pc18 <= `PRIO_RST_18;
			state_reg.pc19 <= `PRIO_RST_19;
			state_reg.pc20 <= `PRIO_RST_20;
		end else begin
			state_reg <= state_next;
		end
	end

	assign s_axi_awready = (state_reg.wst == prio_regs_pkg::wr_idle) && !state_reg.aw_held;
	assign s_axi_wready = (state_reg.wst == prio_regs_pkg::wr_idle) && !state_reg.w_held;
	assign s_axi_bvalid = (state_reg.wst == prio_regs_pkg::wr_resp);
	assign s_axi_bresp = state_reg.bresp;
	assign s_axi_arready = (state_reg.rst == prio_regs_pkg::rd_idle);
	assign s_axi_rvalid = (state_reg.rst == prio_regs_pkg::rd_resp);
	assign s_axi_rdata = state_reg.rdata;
	assign s_axi_rresp = state_reg.rresp;

	// raw codes go out unchanged; the arbiter treats 0 as off, 1..7 as levels
	assign parallel_port_prio = state_reg.pc11[6:4];
	assign out_compare8_prio = state_reg.pc11[2:0];
	assign i2c2_master_prio = state_reg.pc12[10:8];
	assign i2c2_slave_prio = state_reg.pc12[6:4];
	assign ext_irq4_prio = state_reg.pc13[10:8];
	assign ext_irq3_prio = state_reg.pc13[6:4];
	assign calendar_clock_prio = state_reg.pc15[10:8];
	assign checksum_error_prio = state_reg.pc16[14:12];
	assign serial2_error_prio = state_reg.pc16[10:8];
	assign serial1_error_prio = state_reg.pc16[6:4];
	assign low_voltage_prio = state_reg.pc18[2:0];
	assign charge_timer_prio = state_reg.pc19[6:4];
	assign serial3_tx_prio = state_reg.pc20[14:12];
	assign serial3_rx_prio = state_reg.pc20[10:8];
	assign serial3_error_prio = state_reg.pc20[6:4];

	// both halves of a write on one edge, the case the field checks cover
	logic wr_fire;
	assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wready && s_axi_wvalid;

	a_reset_level: assert property (@(posedge aclk)
		!aresetn |=> ext_irq4_prio == `PRIO_FIELD_RST && low_voltage_prio == `PRIO_FIELD_RST)
		else $error("priority not 4 after reset");
	a_reset_all: assert property (@(posedge aclk)
		!aresetn |=> parallel_port_prio == `PRIO_FIELD_RST
		&& out_compare8_prio == `PRIO_FIELD_RST && i2c2_master_prio == `PRIO_FIELD_RST
		&& i2c2_slave_prio == `PRIO_FIELD_RST && ext_irq3_prio == `PRIO_FIELD_RST
		&& calendar_clock_prio == `PRIO_FIELD_RST && checksum_error_prio == `PRIO_FIELD_RST
		&& serial2_error_prio == `PRIO_FIELD_RST && serial1_error_prio == `PRIO_FIELD_RST
		&& charge_timer_prio == `PRIO_FIELD_RST && serial3_tx_prio == `PRIO_FIELD_RST
		&& serial3_rx_prio == `PRIO_FIELD_RST && serial3_error_prio == `PRIO_FIELD_RST)
		else $error("field not 4 after reset");

	a_reg11_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.pc11 & ~`PRIO_MASK_11) == 16'h0000)
		else $error("reg11 reserved bit set");
	a_reg16_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.pc16 & ~`PRIO_MASK_16) == 16'h0000)
		else $error("reg16 reserved bit set");
	a_reg12_13: assert property (@(posedge aclk) disable iff (!aresetn)
		((state_reg.pc12 | state_reg.pc13) & ~`PRIO_MASK_12) == 16'h0000
		&& (state_reg.pc15 & ~`PRIO_MASK_15) == 16'h0000)
		else $error("reserved set");
	a_reg18_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.pc18 & ~`PRIO_MASK_18) == 16'h0000)
		else $error("reg18 reserved bit set");
	a_reg19_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.pc19 & ~`PRIO_MASK_19) == 16'h0000)
		else $error("reg19 reserved bit set");
	a_reg20_mask: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_reg.pc20 & ~`PRIO_MASK_20) == 16'h0000)
		else $error("reg20 reserved bit set");

	a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");

	a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_18
		|=> low_voltage_prio == $past(s_axi_wdata[2:0]))
		else $error("low voltage write lost");
	a_reg20_tx: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_20
		|=> serial3_tx_prio == $past(s_axi_wdata[14:12]))
		else $error("serial3 tx write lost");
	a_pport_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_11
		|=> parallel_port_prio == $past(s_axi_wdata[6:4]))
		else $error("parallel port write lost");
	a_comp8_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_11
		|=> out_compare8_prio == $past(s_axi_wdata[2:0]))
		else $error("compare 8 write lost");
	a_i2c_mst_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_12
		|=> i2c2_master_prio == $past(s_axi_wdata[10:8]))
		else $error("i2c2 master write lost");
	a_i2c_slv_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_12
		|=> i2c2_slave_prio == $past(s_axi_wdata[6:4]))
		else $error("i2c2 slave write lost");
	a_irq4_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_13
		|=> ext_irq4_prio == $past(s_axi_wdata[10:8]))
		else $error("ext irq 4 write lost");
	a_irq3_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_13
		|=> ext_irq3_prio == $past(s_axi_wdata[6:4]))
		else $error("ext irq 3 write lost");
	a_calendar_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_15
		|=> calendar_clock_prio == $past(s_axi_wdata[10:8]))
		else $error("calendar write lost");
	a_checksum_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_16
		|=> checksum_error_prio == $past(s_axi_wdata[14:12]))
		else $error("checksum write lost");
	a_ser2_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_16
		|=> serial2_error_prio == $past(s_axi_wdata[10:8]))
		else $error("serial2 error write lost");
	a_ser1_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_16
		|=> serial1_error_prio == $past(s_axi_wdata[6:4]))
		else $error("serial1 error write lost");
	a_charge_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_19
		|=> charge_timer_prio == $past(s_axi_wdata[6:4]))
		else $error("charge timer write lost");
	a_ser3_rx_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_20
		|=> serial3_rx_prio == $past(s_axi_wdata[10:8]))
		else $error("serial3 rx write lost");
	a_ser3_err_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && s_axi_wstrb[0] && s_axi_awaddr == `PRIO_OFF_20
		|=> serial3_error_prio == $past(s_axi_wdata[6:4]))
		else $error("serial3 error write lost");
	a_lane_off: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !s_axi_wstrb[1] && s_axi_awaddr == `PRIO_OFF_20
		|=> serial3_tx_prio == $past(serial3_tx_prio))
		else $error("unstrobed lane changed");

	a_read_back: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_19
		|=> s_axi_rvalid && s_axi_rdata[6:4] == $past(charge_timer_prio))
		else $error("charge timer readback wrong");
	a_read_reg11: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_11
		|=> s_axi_rdata[15:0] == $past({9'h000, parallel_port_prio, 1'b0, out_compare8_prio}))
		else $error("reg11 readback wrong");
	a_read_reg12: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_12
		|=> s_axi_rdata[15:0] == $past({5'h00, i2c2_master_prio, 1'b0, i2c2_slave_prio, 4'h0}))
		else $error("reg12 readback wrong");
	a_read_reg13: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_13
		|=> s_axi_rdata[15:0] == $past({5'h00, ext_irq4_prio, 1'b0, ext_irq3_prio, 4'h0}))
		else $error("reg13 readback wrong");
	a_read_reg15: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_15
		|=> s_axi_rdata[15:0] == $past({5'h00, calendar_clock_prio, 8'h00}))
		else $error("reg15 readback wrong");
	a_read_reg16: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_16
		|=> s_axi_rdata[15:0] == $past({1'b0, checksum_error_prio, 1'b0, serial2_error_prio,
		1'b0, serial1_error_prio, 4'h0})) else $error("reg16 readback wrong");
	a_read_reg18: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_18
		|=> s_axi_rdata[15:0] == $past({13'h0000, low_voltage_prio}))
		else $error("reg18 readback wrong");
	a_read_reg20: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && s_axi_araddr == `PRIO_OFF_20
		|=> s_axi_rdata[15:0] == $past({1'b0, serial3_tx_prio, 1'b0, serial3_rx_prio,
		1'b0, serial3_error_prio, 4'h0})) else $error("reg20 readback wrong");

	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
	a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_bresp_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
		else $error("write response moved");
	a_aw_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_ar_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_bad_write: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire && !known(s_axi_awaddr) |=> s_axi_bresp == `AXI_RESP_SLVERR)
		else $error("unmapped write not refused");
	a_good_read: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready && known(s_axi_araddr) |=> s_axi_rresp == `AXI_RESP_OKAY)
		else $error("mapped read refused");
	a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_prio_stable: assert property (@(posedge aclk) disable iff (!aresetn)
		!$rose(s_axi_bvalid) |-> $stable({parallel_port_prio, out_compare8_prio,
		i2c2_master_prio, i2c2_slave_prio, ext_irq4_prio, ext_irq3_prio,
		calendar_clock_prio, checksum_error_prio, serial2_error_prio,
		serial1_error_prio, low_voltage_prio, charge_timer_prio, serial3_tx_prio,
		serial3_rx_prio, serial3_error_prio}))
		else $error("priority moved without a write");

	c_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
	c_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
	c_disable: cover property (@(posedge aclk) serial3_error_prio == `PRIO_DISABLED);
	c_bad_addr: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR);
	c_one_lane: cover property (@(posedge aclk) wr_fire && s_axi_wstrb == 4'h2);
endmodule

// File: tb/interrupt_priority_regs_b_bench.sv
// self-checking bench for the interrupt priority register bank
// assumes the defs header on the include path and an axi4-lite master driven here
`timescale 1ns/1ps
`include "prio_regs_defs.svh"

module interrupt_priority_regs_b_bench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [5:0] awaddr = 6'h00, araddr = 6'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [2:0] p[15];
	int n_mismatch = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [5:0] offs[8] = '{`PRIO_OFF_11, `PRIO_OFF_12, `PRIO_OFF_13, `PRIO_OFF_15,
		`PRIO_OFF_16, `PRIO_OFF_18, `PRIO_OFF_19, `PRIO_OFF_20};
	logic [15:0] masks[8] = '{`PRIO_MASK_11, `PRIO_MASK_12, `PRIO_MASK_13, `PRIO_MASK_15,
		`PRIO_MASK_16, `PRIO_MASK_18, `PRIO_MASK_19, `PRIO_MASK_20};
	logic [15:0] rsts[8] = '{`PRIO_RST_11, `PRIO_RST_12, `PRIO_RST_13, `PRIO_RST_15,
		`PRIO_RST_16, `PRIO_RST_18, `PRIO_RST_19, `PRIO_RST_20};

	always #4 aclk = ~aclk;

	interrupt_priority_regs_b i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .parallel_port_prio(p[0]), .out_compare8_prio(p[1]),
		.i2c2_master_prio(p[2]), .i2c2_slave_prio(p[3]), .ext_irq4_prio(p[4]),
		.ext_irq3_prio(p[5]), .calendar_clock_prio(p[6]), .checksum_error_prio(p[7]),
		.serial2_error_prio(p[8]), .serial1_error_prio(p[9]), .low_voltage_prio(p[10]),
		.charge_timer_prio(p[11]), .serial3_tx_prio(p[12]), .serial3_rx_prio(p[13]),
		.serial3_error_prio(p[14]));

	task automatic stop_test();
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// hang guard at 20000 cycles, far above the few hundred this sequence needs
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// handshakes are sampled mid-cycle, inputs only move at rising edges
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] exp_resp);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] resp;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs) begin
			@(negedge aclk);
			aw_hs = awvalid & awready;
			w_hs = wvalid & wready;
			b_hs = bvalid & bready;
			resp = bresp;
			@(posedge aclk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (b_hs) bready <= 1'b0;
		end
		check("bresp", {30'h0, resp}, {30'h0, exp_resp});
	endtask

	task automatic axi_read(input logic [5:0] a, input logic [31:0] exp_d,
		input logic [1:0] exp_resp);
		logic ar_hs, r_hs;
		logic [31:0] d;
		logic [1:0] resp;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs) begin
			@(negedge aclk);
			ar_hs = arvalid & arready;
			r_hs = rvalid & rready;
			d = rdata;
			resp = rresp;
			@(posedge aclk);
			if (ar_hs) arvalid <= 1'b0;
			if (r_hs) rready <= 1'b0;
		end
		check("rdata", d, exp_d);
		check("rresp", {30'h0, resp}, {30'h0, exp_resp});
	endtask

	task automatic check_prios(input logic [2:0] k);
		@(negedge aclk);
		for (int i = 0; i < 15; i++) begin
			check("prio output", {29'h0, p[i]}, {29'h0, k});
		end
	endtask

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	initial begin
		logic [15:0] pat;
		do_reset();
		for (int i = 0; i < 8; i++) axi_read(offs[i], {16'h0, rsts[i]}, `AXI_RESP_OKAY);
		check_prios(3'h4);
		$display("test reset_values done");
		// reserved bits and upper half are written as ones and must not stick
		for (int k = 0; k < 8; k++) begin
			pat = 16'h1111 * k[15:0];
			for (int i = 0; i < 8; i++) begin
				axi_write(offs[i], {16'hffff, pat | 16'h8888}, 4'hf, `AXI_RESP_OKAY);
				axi_read(offs[i], {16'h0, pat & masks[i]}, `AXI_RESP_OKAY);
			end
			check_prios(k[2:0]);
		end
		$display("test field_codes done");
		axi_write(`PRIO_OFF_20, 32'h0, 4'h2, `AXI_RESP_OKAY);
		axi_read(`PRIO_OFF_20, 32'h0000_0070, `AXI_RESP_OKAY);
		check("serial3 rx", {29'h0, p[13]}, 32'h0);
		check("serial3 tx", {29'h0, p[12]}, 32'h0);
		check("serial3 error", {29'h0, p[14]}, 32'h7);
		$display("test byte_strobe done");
		axi_write(6'h20, 32'h0000_7777, 4'hf, `AXI_RESP_SLVERR);
		axi_read(6'h20, 32'h0, `AXI_RESP_SLVERR);
		axi_read(`PRIO_OFF_16, 32'h0000_7770, `AXI_RESP_OKAY);
		$display("test unmapped done");
		@(posedge aclk);
		do_reset();
		for (int i = 0; i < 8; i++) axi_read(offs[i], {16'h0, rsts[i]}, `AXI_RESP_OKAY);
		check_prios(3'h4);
		$display("test second_reset done");
		stop_test();
	end
endmodule
